// ---- hw/line_maintenance_monitor.sv ----
// Line maintenance monitor: dropout detection, zero-run counting, loopbacks
//
// Functional notes
// R1 - Long haul declare level: code 0 is 4 dB, 2 dB steps, floor 48 dB
// R2 - Short haul ignores the declare-level field and uses the fixed level
// R3 - Peak observation window of 32, 64, 128 or 256 bits
// R4 - Six independent loopback enables, active high
// R5 - Criterion 0 declares dropout after 175 bits below declare level
// R6 - Criterion 1 declares dropout after 1544 bits below declare level
// R7 - Clear needs level above clear, 16 marks, under 100 zeros in 128 bits
// R8 - Long haul clear level sits 4 dB above the declare threshold
// R9 - Receive all-ones toward system while dropout and enabled
// R10 - Transmit all-ones toward line while dropout and enabled
// R11 - Each rising edge of the insert bit makes exactly one violation
// R12 - Standard 0: zero-run error above 15 in AMI, above 7 in B8ZS
// R13 - Standard 1: zero-run error above 80 in AMI, above 7 in B8ZS
// R14 - Zero-run errors counted in 16 bits only while enable field is 01
// R15 - Manual mode copies counter on each rising edge of transfer bit
// R16 - Automatic mode copies counter once every second
// R17 - Transfer bit ignored in automatic mode
// R18 - Line-code bit 0 decodes B8ZS, 1 decodes AMI; sets zero limit
// R19 - Equalizer on means long haul, off means short haul
// R20 - Bit counts advance on a per-bit enable from recovered clock
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module line_maintenance_monitor #(
   parameter longint ONE_SEC_CYCLES = line_maint_pkg::ONE_SECOND_CYCLES
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [line_maint_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Receive line, asynchronous to CLK_SYS
   input wire logic RX_LINE_CLK,
   input wire logic RX_POS,
   input wire logic RX_NEG,
   input wire logic RX_BELOW_DECLARE,
   input wire logic RX_ABOVE_CLEAR,
   // Analog front-end control
   output logic LONG_HAUL,
   output logic [5:0] DECLARE_LEVEL_DB,
   output logic [5:0] CLEAR_LEVEL_DB,
   output logic PEAK_WINDOW_END,
   // Receive toward system
   output logic RX_DATA,
   output logic RX_DATA_VALID,
   // Transmit from system toward line
   input wire logic TX_BIT_EN,
   input wire logic TX_DATA,
   output logic TX_POS,
   output logic TX_NEG,
   // Maintenance state
   output logic [5:0] LOOPBACK_EN,
   output logic DROPOUT
);

   localparam int SEC_W = $clog2(ONE_SEC_CYCLES + 1);
   localparam int NSYNC = 5;

   line_maint_pkg::ctrl_regs_s regs;
   line_maint_pkg::dropout_state_e state;
   logic [NSYNC-1:0] sync1, sync2, sync3, filt;
   logic clk_prev, bit_en;
   logic f_clk, f_pos, f_neg, f_below, f_above;
   logic [7:0] pos_sh, neg_sh;
   logic [2:0] kill_cnt;
   logic last_pol, b8zs_hit, kill_now, out_mark;
   logic [7:0] zero_run, next_zero_run, exz_limit;
   logic exz_hit, long_haul, b8zs_mode, los;
   logic [10:0] below_run, declare_limit;
   logic [6:0] win_cnt;
   logic [7:0] win_marks, next_marks;
   logic win_ok, next_ok;
   logic [7:0] peak_cnt, peak_len;
   logic bpv_prev, bpv_pend, tx_last_pos, tx_one;
   logic trf_prev, manual_xfer, sec_tick, xfer_now, count_inc;
   logic [SEC_W-1:0] sec_cnt;
   logic [15:0] exz_cnt, exz_result;
   logic [7:0] rd_byte;
   logic hit;

   // Hit flag for an aligned word address of a listed register
   function automatic logic decode_hit(input logic [11:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      decode_hit = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) &&
         (idx == line_maint_pkg::IDX_RX_DECODE ||
          idx == line_maint_pkg::IDX_RX_LEVEL ||
          idx == line_maint_pkg::IDX_SLICER ||
          idx == line_maint_pkg::IDX_LOOPBACK ||
          idx == line_maint_pkg::IDX_DROPOUT ||
          idx == line_maint_pkg::IDX_ZERO_RUN ||
          idx == line_maint_pkg::IDX_TERM ||
          idx == line_maint_pkg::IDX_STATUS ||
          idx == line_maint_pkg::IDX_CNT_LO ||
          idx == line_maint_pkg::IDX_CNT_HI);
   endfunction : decode_hit

   assign hit = decode_hit(PADDR);
   assign PREADY = 1'b1;

   // Register writes take effect in the access phase
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         regs.rx_decode <= line_maint_pkg::RST_RX_DECODE;
         regs.rx_level <= line_maint_pkg::RST_RX_LEVEL;
         regs.slicer <= line_maint_pkg::RST_SLICER;
         regs.loopback <= line_maint_pkg::RST_LOOPBACK;
         regs.dropout <= line_maint_pkg::RST_DROPOUT;
         regs.zero_run <= line_maint_pkg::RST_ZERO_RUN;
         regs.term <= line_maint_pkg::RST_TERM;
      end else if (PSEL && PENABLE && PWRITE && hit) begin
         case (PADDR[9:2])
            line_maint_pkg::IDX_RX_DECODE:
               regs.rx_decode <= PWDATA[7:0] & line_maint_pkg::WM_RX_DECODE;
            line_maint_pkg::IDX_RX_LEVEL:
               regs.rx_level <= PWDATA[7:0] & line_maint_pkg::WM_RX_LEVEL;
            line_maint_pkg::IDX_SLICER:
               regs.slicer <= PWDATA[7:0] & line_maint_pkg::WM_SLICER;
            line_maint_pkg::IDX_LOOPBACK:
               regs.loopback <= PWDATA[7:0] & line_maint_pkg::WM_LOOPBACK;
            line_maint_pkg::IDX_DROPOUT:
               regs.dropout <= PWDATA[7:0] & line_maint_pkg::WM_DROPOUT;
            line_maint_pkg::IDX_ZERO_RUN:
               regs.zero_run <= PWDATA[7:0] & line_maint_pkg::WM_ZERO_RUN;
            line_maint_pkg::IDX_TERM:
               regs.term <= PWDATA[7:0] & line_maint_pkg::WM_TERM;
            default: ;
         endcase
      end
   end

   always_comb begin
      case (PADDR[9:2])
         line_maint_pkg::IDX_RX_DECODE: rd_byte = regs.rx_decode;
         line_maint_pkg::IDX_RX_LEVEL: rd_byte = regs.rx_level;
         line_maint_pkg::IDX_SLICER: rd_byte = regs.slicer;
         line_maint_pkg::IDX_LOOPBACK: rd_byte = regs.loopback;
         line_maint_pkg::IDX_DROPOUT: rd_byte = regs.dropout;
         line_maint_pkg::IDX_ZERO_RUN: rd_byte = regs.zero_run;
         line_maint_pkg::IDX_TERM: rd_byte = regs.term;
         line_maint_pkg::IDX_STATUS: rd_byte = {7'h00, los};
         line_maint_pkg::IDX_CNT_LO: rd_byte = exz_result[7:0];
         line_maint_pkg::IDX_CNT_HI: rd_byte = exz_result[15:8];
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data and error are captured in the setup phase
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PRDATA <= hit ? {24'h0, rd_byte} : 32'h0;
         PSLVERR <= !hit;
      end
   end

   // Three-stage synchronisers; a change counts once stages two and three agree
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
               sync3[i] <= 1'b0;
               filt[i] <= 1'b0;
            end else begin
               sync1[i] <= (i == 0) ? RX_LINE_CLK : (i == 1) ? RX_POS :
                  (i == 2) ? RX_NEG : (i == 3) ? RX_BELOW_DECLARE :
                  RX_ABOVE_CLEAR;
               sync2[i] <= sync1[i];
               sync3[i] <= sync2[i];
               if (sync2[i] == sync3[i]) begin
                  filt[i] <= sync3[i];
               end
            end
         end
      end
   endgenerate

   assign {f_above, f_below, f_neg, f_pos, f_clk} = filt;

   // One enable per recovered bit
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         clk_prev <= 1'b0;
      end else begin
         clk_prev <= f_clk;
      end
   end
   assign bit_en = f_clk && !clk_prev; // R20

   assign long_haul = regs.rx_level[line_maint_pkg::F_EQUALIZER_LONG_HAUL_ON]; // R19
   assign b8zs_mode = !regs.rx_decode[line_maint_pkg::F_LINE_CODE]; // R18
   assign los = (state == line_maint_pkg::SIG_LOST);

   // Substitution 000VB0VB: V repeats the previous polarity
   assign b8zs_hit = b8zs_mode && (kill_cnt == 3'h0) &&
      !(pos_sh[7] | neg_sh[7]) && !(pos_sh[6] | neg_sh[6]) &&
      !(pos_sh[5] | neg_sh[5]) && (pos_sh[4] ^ neg_sh[4]) &&
      (pos_sh[4] == last_pol) && (pos_sh[3] ^ neg_sh[3]) &&
      (pos_sh[3] != pos_sh[4]) && !(pos_sh[2] | neg_sh[2]) &&
      (pos_sh[1] ^ neg_sh[1]) && (pos_sh[1] == pos_sh[3]) &&
      (pos_sh[0] ^ neg_sh[0]) && (pos_sh[0] != pos_sh[1]); // R18
   assign kill_now = b8zs_hit || (kill_cnt != 3'h0);
   assign out_mark = (pos_sh[7] | neg_sh[7]) && !kill_now;

   // Eight-bit decode pipeline
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         pos_sh <= 8'h0;
         neg_sh <= 8'h0;
         kill_cnt <= 3'h0;
         last_pol <= 1'b0;
      end else if (bit_en) begin
         pos_sh <= {pos_sh[6:0], f_pos};
         neg_sh <= {neg_sh[6:0], f_neg};
         if (b8zs_hit) begin
            kill_cnt <= 3'h7;
         end else if (kill_cnt != 3'h0) begin
            kill_cnt <= kill_cnt - 3'h1;
         end
         if (pos_sh[7] ^ neg_sh[7]) begin
            last_pol <= pos_sh[7];
         end
      end
   end

   // Zero-run limits
   always_comb begin
      if (b8zs_mode) begin
         exz_limit = 8'(line_maint_pkg::EXZ_B8ZS); // R12 R13
      end else if (regs.zero_run[line_maint_pkg::F_ZERO_RUN_STANDARD_SELECT]) begin
         exz_limit = 8'(line_maint_pkg::EXZ_AMI_FCC); // R13
      end else begin
         exz_limit = 8'(line_maint_pkg::EXZ_AMI_ANSI); // R12
      end
   end
   assign next_zero_run = out_mark ? 8'h0 :
      (zero_run == 8'hff) ? zero_run : zero_run + 8'h1;
   // Flags once per run, on the first zero past the limit
   assign exz_hit = bit_en && !out_mark && (zero_run == exz_limit); // R12

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         zero_run <= 8'h0;
      end else if (bit_en) begin
         zero_run <= next_zero_run;
      end
   end

   // Dropout declare and clear
   assign declare_limit = regs.dropout[line_maint_pkg::F_LAC] ?
      11'(line_maint_pkg::DECLARE_BITS_I431) :
      11'(line_maint_pkg::DECLARE_BITS_T1231); // R5 R6
   assign next_marks = win_marks + {7'h0, out_mark};
   assign next_ok = win_ok && f_above &&
      (next_zero_run < 8'(line_maint_pkg::CLEAR_MAX_ZERO_RUN)); // R7

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         below_run <= 11'h0;
      end else if (bit_en) begin
         if (!f_below || los) begin
            below_run <= 11'h0;
         end else if (below_run != declare_limit) begin
            below_run <= below_run + 11'h1;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         win_cnt <= 7'h0;
         win_marks <= 8'h0;
         win_ok <= 1'b1;
      end else if (bit_en) begin
         win_cnt <= win_cnt + 7'h1;
         if (win_cnt == 7'(line_maint_pkg::CLEAR_WINDOW_BITS - 1)) begin
            win_marks <= 8'h0;
            win_ok <= 1'b1;
         end else begin
            win_marks <= next_marks;
            win_ok <= next_ok;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         state <= line_maint_pkg::SIG_PRESENT;
      end else if (bit_en) begin
         case (state)
            line_maint_pkg::SIG_PRESENT: begin
               if (f_below && below_run == declare_limit - 11'h1) begin
                  state <= line_maint_pkg::SIG_LOST; // R5 R6
               end
            end
            line_maint_pkg::SIG_LOST: begin
               if (win_cnt == 7'(line_maint_pkg::CLEAR_WINDOW_BITS - 1) &&
                  next_ok && next_marks >=
                  8'(line_maint_pkg::CLEAR_MIN_MARKS)) begin
                  state <= line_maint_pkg::SIG_PRESENT; // R7
               end
            end
            default: state <= line_maint_pkg::SIG_PRESENT;
         endcase
      end
   end

   // Threshold codes toward the comparators; zero selects the fixed level
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         LONG_HAUL <= 1'b0;
         DECLARE_LEVEL_DB <= 6'h0;
         CLEAR_LEVEL_DB <= 6'h0;
      end else begin
         LONG_HAUL <= long_haul;
         if (long_haul) begin
            DECLARE_LEVEL_DB <= line_maint_pkg::level_db(
               regs.rx_level[line_maint_pkg::F_LEVEL_LSB +: 5]); // R1
            CLEAR_LEVEL_DB <= line_maint_pkg::level_db(
               regs.rx_level[line_maint_pkg::F_LEVEL_LSB +: 5]) -
               line_maint_pkg::HYSTERESIS_DB; // R8
         end else begin
            DECLARE_LEVEL_DB <= 6'h0; // R2
            CLEAR_LEVEL_DB <= 6'h0;
         end
      end
   end

   // Peak observation window
   assign peak_len = 8'(line_maint_pkg::PEAK_WIN_BASE <<
      regs.slicer[line_maint_pkg::F_UPDW_LSB +: 2]);
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         peak_cnt <= 8'h0;
         PEAK_WINDOW_END <= 1'b0;
      end else begin
         PEAK_WINDOW_END <= bit_en && (peak_cnt >= peak_len - 8'h1); // R3
         if (bit_en) begin
            peak_cnt <= (peak_cnt >= peak_len - 8'h1) ? 8'h0 :
               peak_cnt + 8'h1; // R3
         end
      end
   end

   // Receive data toward the system side
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         RX_DATA <= 1'b0;
         RX_DATA_VALID <= 1'b0;
      end else begin
         RX_DATA_VALID <= bit_en;
         if (bit_en) begin
            RX_DATA <= out_mark ||
               (regs.dropout[line_maint_pkg::F_RAISE] && los); // R9
         end
      end
   end

   // Transmit AMI encoder with one-shot violation
   assign tx_one = TX_DATA ||
      (regs.dropout[line_maint_pkg::F_TX_ALL_ONES_ON_DROPOUT_EN] && los); // R10
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         bpv_prev <= 1'b0;
         bpv_pend <= 1'b0;
         tx_last_pos <= 1'b0;
         TX_POS <= 1'b0;
         TX_NEG <= 1'b0;
      end else begin
         bpv_prev <= regs.zero_run[line_maint_pkg::F_BPV];
         // A new request wins over consumption of the previous one
         if (regs.zero_run[line_maint_pkg::F_BPV] && !bpv_prev) begin
            bpv_pend <= 1'b1; // R11
         end else if (TX_BIT_EN && tx_one) begin
            bpv_pend <= 1'b0; // R11
         end
         if (TX_BIT_EN) begin
            if (tx_one) begin
               // Violation repeats the last polarity instead of alternating
               TX_POS <= bpv_pend ? tx_last_pos : !tx_last_pos; // R11
               TX_NEG <= bpv_pend ? !tx_last_pos : tx_last_pos;
               tx_last_pos <= bpv_pend ? tx_last_pos : !tx_last_pos;
            end else begin
               TX_POS <= 1'b0;
               TX_NEG <= 1'b0;
            end
         end
      end
   end

   // Zero-run error counter and reporting
   assign manual_xfer = regs.zero_run[line_maint_pkg::F_COUNTER_TRANSFER_TRIGGER] &&
      !trf_prev && !regs.zero_run[line_maint_pkg::F_COUNTER_REPORT_MODE]; // R15 R17
   assign sec_tick = (sec_cnt == SEC_W'(ONE_SEC_CYCLES - 1));
   assign xfer_now = manual_xfer ||
      (regs.zero_run[line_maint_pkg::F_COUNTER_REPORT_MODE] && sec_tick); // R16
   assign count_inc = exz_hit && (regs.zero_run[
      line_maint_pkg::F_EXZ_ERR_LSB +: 2] == line_maint_pkg::EXZ_COUNT_ON);

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         trf_prev <= 1'b0;
         sec_cnt <= '0;
      end else begin
         trf_prev <= regs.zero_run[line_maint_pkg::F_COUNTER_TRANSFER_TRIGGER];
         sec_cnt <= sec_tick ? '0 : sec_cnt + SEC_W'(1);
      end
   end

   // Transfer restarts the count; an event in the same cycle is kept
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         exz_cnt <= 16'h0;
         exz_result <= 16'h0;
      end else begin
         if (xfer_now) begin
            exz_result <= exz_cnt; // R15 R16
            exz_cnt <= {15'h0, count_inc};
         end else if (count_inc) begin
            exz_cnt <= exz_cnt + 16'h1; // R14
         end
      end
   end

   assign LOOPBACK_EN = {regs.loopback[6:4], regs.loopback[2:0]}; // R4
   assign DROPOUT = los;

   // Checks
   dropout_declare_a: assert property (@(posedge CLK_SYS) // R5 R6
      disable iff (!NRST)
      (bit_en && !los && f_below && below_run == declare_limit - 11'h1)
      |=> los) else $error("dropout not declared at limit");
   early_declare_a: assert property (@(posedge CLK_SYS) // R5 R6
      disable iff (!NRST)
      $rose(los) |-> $past(below_run) == declare_limit - 11'h1)
      else $error("dropout declared early");
   dropout_clear_a: assert property (@(posedge CLK_SYS) // R7
      disable iff (!NRST)
      $fell(los) |-> $past(win_cnt) == 7'h7f && $past(f_above))
      else $error("dropout cleared outside window");
   rx_all_ones_a: assert property (@(posedge CLK_SYS) // R9
      disable iff (!NRST)
      (bit_en && los && regs.dropout[line_maint_pkg::F_RAISE]) |=>
      RX_DATA && RX_DATA_VALID) else $error("rx all ones missing");
   tx_all_ones_a: assert property (@(posedge CLK_SYS) // R10
      disable iff (!NRST)
      (TX_BIT_EN && los && regs.dropout[line_maint_pkg::F_TX_ALL_ONES_ON_DROPOUT_EN]) |=>
      (TX_POS ^ TX_NEG)) else $error("tx all ones missing");
   single_bpv_a: assert property (@(posedge CLK_SYS) // R11
      disable iff (!NRST)
      (TX_BIT_EN && tx_one && bpv_pend &&
      !(regs.zero_run[line_maint_pkg::F_BPV] && !bpv_prev))
      |=> !bpv_pend && TX_POS == $past(tx_last_pos) &&
      TX_NEG == !$past(tx_last_pos))
      else $error("violation not single");
   exz_count_a: assert property (@(posedge CLK_SYS) // R14
      disable iff (!NRST)
      (count_inc && !xfer_now) |=> exz_cnt == $past(exz_cnt) + 16'h1)
      else $error("event not counted");
   manual_copy_a: assert property (@(posedge CLK_SYS) // R15
      disable iff (!NRST)
      manual_xfer |=> exz_result == $past(exz_cnt))
      else $error("manual transfer lost");
   auto_ignore_a: assert property (@(posedge CLK_SYS) // R17
      disable iff (!NRST)
      (regs.zero_run[line_maint_pkg::F_COUNTER_REPORT_MODE] && !sec_tick) |=>
      $stable(exz_result))
      else $error("result changed off the second tick");
   clear_hyst_a: assert property (@(posedge CLK_SYS) // R8
      disable iff (!NRST)
      LONG_HAUL |-> DECLARE_LEVEL_DB == CLEAR_LEVEL_DB + 6'h4)
      else $error("hysteresis wrong");
   peak_window_a: assert property (@(posedge CLK_SYS) // R3
      disable iff (!NRST)
      PEAK_WINDOW_END |-> $past(peak_cnt) == $past(peak_len) - 8'h1)
      else $error("peak window length wrong");

endmodule : line_maintenance_monitor
`default_nettype wire

// ---- pkg/line_maint_pkg.sv ----
// Register map, field layout, timing constants and types of the line monitor
package line_maint_pkg;

   // Register indices; byte address is four times the index
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_RX_DECODE = 8'h28;
   localparam logic [7:0] IDX_RX_LEVEL = 8'h29;
   localparam logic [7:0] IDX_SLICER = 8'h2a;
   localparam logic [7:0] IDX_LOOPBACK = 8'h2b;
   localparam logic [7:0] IDX_DROPOUT = 8'h2c;
   localparam logic [7:0] IDX_ZERO_RUN = 8'h31;
   localparam logic [7:0] IDX_TERM = 8'h32;
   localparam logic [7:0] IDX_STATUS = 8'h40;
   localparam logic [7:0] IDX_CNT_LO = 8'h41;
   localparam logic [7:0] IDX_CNT_HI = 8'h42;

   // Reset values
   localparam logic [7:0] RST_RX_DECODE = 8'h00;
   localparam logic [7:0] RST_RX_LEVEL = 8'h15;
   localparam logic [7:0] RST_SLICER = 8'h18;
   localparam logic [7:0] RST_LOOPBACK = 8'h00;
   localparam logic [7:0] RST_DROPOUT = 8'h00;
   localparam logic [7:0] RST_ZERO_RUN = 8'h00;
   localparam logic [7:0] RST_TERM = 8'h07;

   // Writable bits; reserved bits read as zero
   localparam logic [7:0] WM_RX_DECODE = 8'h11;
   localparam logic [7:0] WM_RX_LEVEL = 8'h5f;
   localparam logic [7:0] WM_SLICER = 8'h3f;
   localparam logic [7:0] WM_LOOPBACK = 8'h77;
   localparam logic [7:0] WM_DROPOUT = 8'h07;
   localparam logic [7:0] WM_ZERO_RUN = 8'h5f;
   localparam logic [7:0] WM_TERM = 8'h1f;

   // Field positions
   localparam int F_LINE_CODE = 0;
   localparam int F_EQUALIZER_LONG_HAUL_ON = 6;
   localparam int F_LEVEL_LSB = 0;
   localparam int F_UPDW_LSB = 2;
   localparam int F_LAC = 2;
   localparam int F_RAISE = 1;
   localparam int F_TX_ALL_ONES_ON_DROPOUT_EN = 0;
   localparam int F_BPV = 6;
   localparam int F_ZERO_RUN_STANDARD_SELECT = 4;
   localparam int F_EXZ_ERR_LSB = 2;
   localparam int F_COUNTER_REPORT_MODE = 1;
   localparam int F_COUNTER_TRANSFER_TRIGGER = 0;
   localparam int F_ST_DROPOUT = 0;
   localparam logic [1:0] EXZ_COUNT_ON = 2'h1;

   // Bit-interval counts
   localparam int DECLARE_BITS_T1231 = 175;
   localparam int DECLARE_BITS_I431 = 1544;
   localparam int CLEAR_WINDOW_BITS = 128;
   localparam int CLEAR_MIN_MARKS = CLEAR_WINDOW_BITS / 8;
   localparam int CLEAR_MAX_ZERO_RUN = 100;
   localparam int EXZ_B8ZS = 7;
   localparam int EXZ_AMI_ANSI = 15;
   localparam int EXZ_AMI_FCC = 80;
   localparam int PEAK_WIN_BASE = 32;

   // Threshold levels in dB below nominal
   localparam logic [5:0] THRESH_BASE_DB = 6'h04;
   localparam logic [5:0] THRESH_FLOOR_DB = 6'h30;
   localparam logic [4:0] THRESH_FLOOR_CODE = 5'h16;
   localparam logic [5:0] HYSTERESIS_DB = 6'h04;

   // Report period
   localparam longint ONE_SECOND_S = 1;
   localparam longint CLK_HZ = 10_000_000;
   localparam longint ONE_SECOND_CYCLES = ONE_SECOND_S * CLK_HZ;

   typedef enum logic [0:0] {
      SIG_PRESENT = 1'b0,
      SIG_LOST = 1'b1
   } dropout_state_e;

   typedef struct packed {
      logic [7:0] rx_decode;
      logic [7:0] rx_level;
      logic [7:0] slicer;
      logic [7:0] loopback;
      logic [7:0] dropout;
      logic [7:0] zero_run;
      logic [7:0] term;
   } ctrl_regs_s;

   function automatic logic [5:0] level_db(input logic [4:0] code);
      if (code >= THRESH_FLOOR_CODE) begin
         level_db = THRESH_FLOOR_DB;
      end else begin
         level_db = THRESH_BASE_DB + {code, 1'b0};
      end
   endfunction : level_db

endpackage : line_maint_pkg

// ---- test/line_partner.sv ----
// Remote line equipment model: line clock, marks and level flags
`timescale 1ns/1ps
`default_nettype none
module line_partner (
   // Control from bench
   input wire logic quiet,
   // Line toward device
   output logic line_clk,
   output logic pos,
   output logic neg,
   output logic below,
   output logic above
);
   logic pol;
   // T1 line runs continuously, so the clock never stops; marks alternate
   // and change on the falling edge so they are stable when taken
   initial begin
      {line_clk, pol, pos, neg} = 4'h0;
      forever begin
         #324 line_clk = 1'b1;
         #324 line_clk = 1'b0;
         pos = !quiet && pol;
         neg = !quiet && !pol;
         pol = !pol;
      end
   end
   assign below = quiet;
   assign above = !quiet;
endmodule : line_partner
`default_nettype wire

// ---- test/test_line_maintenance_monitor.sv ----
// Self-checking bench of the line maintenance monitor
`timescale 1ns/1ps
`default_nettype none
module test_line_maintenance_monitor;
   logic clk, nrst, psel, penable, pwrite, ten, tdat, quiet, lclk, pos, neg;
   logic pready, slverr, bel, abv, rdat, rval, txp, txn, drop, lh, pwe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0] dlev, clev, lpb, exp_db;
   logic [8:0] cnt, q[$];
   logic [7:0] v;
   logic [4:0] code;
   int n_mismatch, n_tests, seed;
   line_maintenance_monitor #(.ONE_SEC_CYCLES(200)) u_dut (.CLK_SYS(clk),
      .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(slverr), .RX_LINE_CLK(lclk), .RX_POS(pos), .RX_NEG(neg),
      .RX_BELOW_DECLARE(bel), .RX_ABOVE_CLEAR(abv), .LONG_HAUL(lh),
      .DECLARE_LEVEL_DB(dlev), .CLEAR_LEVEL_DB(clev), .PEAK_WINDOW_END(pwe),
      .RX_DATA(rdat), .RX_DATA_VALID(rval), .TX_BIT_EN(ten), .TX_DATA(tdat),
      .TX_POS(txp), .TX_NEG(txn), .LOOPBACK_EN(lpb), .DROPOUT(drop));
   line_partner u_line (.quiet(quiet), .line_clk(lclk), .pos(pos),
      .neg(neg), .below(bel), .above(abv));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input logic [8:0] s, input logic [8:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [7:0] idx, input logic [8:0] e);
      q.push_back(e);
      apb(1'b0, idx, 8'h00);
   endtask : rd
   task tx(input logic d);
      @(posedge clk);
      ten <= 1'b1;
      tdat <= d;
      @(posedge clk);
      ten <= 1'b0;
      @(negedge clk);
   endtask : tx
   // Oldest note is matched against each completed read
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         chk({slverr, prdata[7:0]}, q.pop_front());
      end
   end
   task results;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   initial begin
      #2000000;
      n_mismatch++;
      results;
   end
   initial begin
      {nrst, psel, penable, pwrite, ten, tdat, quiet} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      seed = 32'h37077f1d;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd(line_maint_pkg::IDX_SLICER, {1'b0, line_maint_pkg::RST_SLICER});
      rd(line_maint_pkg::IDX_TERM, {1'b0, line_maint_pkg::RST_TERM});
      rd(8'h3f, 9'h100);
      v = $random(seed);
      apb(1'b1, line_maint_pkg::IDX_LOOPBACK, v);
      rd(line_maint_pkg::IDX_LOOPBACK, {1'b0, v & 8'h77});
      @(negedge clk) chk({3'h0, lpb}, {3'h0, v[6:4], v[2:0]});
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         code = i[1] ? (i[0] ? 5'h1f : 5'h16) : (i[0] ? 5'h15 : 5'h00);
         exp_db = (code >= 5'h16) ? 6'h30 : 6'h04 + {code, 1'b0};
         apb(1'b1, line_maint_pkg::IDX_RX_LEVEL, {3'h2, code});
         repeat (2) @(negedge clk);
         chk({2'h0, lh, dlev}, {3'h1, exp_db});
         chk({3'h0, clev}, {3'h0, exp_db - 6'h04});
      end
      // Short haul: the external comparator's fixed level applies
      apb(1'b1, line_maint_pkg::IDX_RX_LEVEL, 8'h15);
      @(negedge clk);
      repeat (2) @(negedge clk) chk({2'h0, lh, dlev}, 9'h000);
      do @(negedge clk); while (pwe !== 1'b1);
      cnt = 9'h000;
      do begin
         @(negedge clk);
         cnt += {8'h0, rval};
      end while (pwe !== 1'b1);
      chk(cnt, 9'h080);
      $display("levels done");
      apb(1'b1, line_maint_pkg::IDX_DROPOUT, 8'h03);
      quiet = 1'b1;
      repeat (150) @(posedge lclk);
      @(negedge clk) chk({8'h0, drop}, 9'h000);
      repeat (35) @(posedge lclk);
      repeat (10) @(negedge clk);
      chk({8'h0, drop}, 9'h001);
      rd(line_maint_pkg::IDX_STATUS, 9'h001);
      do @(negedge clk); while (rval !== 1'b1);
      chk({8'h0, rdat}, 9'h001);
      tx(1'b0);
      chk({8'h0, txp | txn}, 9'h001);
      quiet = 1'b0;
      repeat (300) @(posedge lclk);
      @(negedge clk) chk({8'h0, drop}, 9'h000);
      $display("dropout done");
      apb(1'b1, line_maint_pkg::IDX_ZERO_RUN, 8'h44);
      v[1:0] = {txp, txn};
      tx(1'b1);
      chk({7'h0, txp, txn}, {7'h0, v[1:0]});
      tx(1'b1);
      chk({7'h0, txp, txn}, {7'h0, v[0], v[1]});
      quiet = 1'b1;
      repeat (20) @(posedge lclk);
      quiet = 1'b0;
      repeat (20) @(posedge lclk);
      apb(1'b1, line_maint_pkg::IDX_ZERO_RUN, 8'h45);
      rd(line_maint_pkg::IDX_CNT_LO, 9'h001);
      rd(line_maint_pkg::IDX_CNT_HI, 9'h000);
      apb(1'b1, line_maint_pkg::IDX_ZERO_RUN, 8'h06);
      repeat (200) @(posedge clk);
      rd(line_maint_pkg::IDX_CNT_LO, 9'h000);
      @(negedge clk);
      $display("counter done");
      results;
   end
endmodule : test_line_maintenance_monitor
`default_nettype wire
